//--- src/fbr_boot_ctrl.sv
// boot-time controller for flash reprogramming: strap decode, serial
// password check, routine copy to ram, hand-off and flash read gating
// assumes byte-level serial receive/transmit around it and a cpu that
// follows the exec pulse; software drives the user boot request level
`include "fbr_map.svh"

// Operation
// - boot pin at reset release enters serial boot
// - check password; erased flash uses 0xFF
// - copy routine to ram only after pass
// - jump to ram routine after copy
// - no boot pin means normal mode run
// - reset routine mode check enters user boot
// - flash reads blocked during erase/program
// - reset returns flash to normal mode
// - ack checksum with 0x40, 0x41, 0x48
module fbr_boot_ctrl (
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  input  wire logic                    BOOT_PIN,
  input  wire logic                    USER_BOOT_REQ,
  input  wire logic                    FLASH_ERASED,
  input  wire logic [`FBR_PW_BITS-1:0] STORED_PW,
  input  wire fbr_pkg::fbr_rx_t        RX,
  output      logic                    TX_VALID,
  output      logic [7:0]              TX_DATA,
  input  wire logic                    TX_READY,
  output      fbr_pkg::fbr_ram_wr_t    RAM_WR,
  output      logic                    EXEC_GO,
  output      logic [31:0]             EXEC_ADDR,
  output      fbr_pkg::fbr_flash_mode_t FLASH_MODE,
  input  wire logic                    FLASH_BUSY,
  input  wire logic [31:0]             FLASH_RDATA_IN,
  output      logic [31:0]             FLASH_RDATA
);
  import fbr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state and working registers
  fbr_state_t      state;       // controller state
  fbr_state_t      next_state;  // state for next edge
  logic [3:0]      pw_idx;      // password byte index
  logic [7:0]      sum;         // running byte sum
  logic            comm_err;    // receive error seen
  logic            pw_err;      // password mismatch seen
  logic [15:0]     remain;      // routine bytes still to copy
  logic [31:0]     wr_addr;     // next ram address
  logic            load_ok;     // password check passed

  // byte of the expected password at a given index
  function automatic logic [7:0] fbr_pw_byte(input logic [`FBR_PW_BITS-1:0] pw,
                                             input logic [3:0] idx,
                                             input logic erased);
    logic [7:0] b;
    b = pw[idx[2:0]*8 +: 8];
    fbr_pw_byte = erased ? `FBR_ERASED_BYTE : b;
  endfunction

  // ram window check: start to last ram address
  function automatic logic wire_le(input logic [31:0] a);
    wire_le = (a >= `FBR_RAM_START) && (a <= `FBR_RAM_END);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode wires
  wire        rx_ok      = RX.valid & ~RX.err;  // clean byte arrived
  wire [7:0]  exp_pw     = fbr_pw_byte(STORED_PW, pw_idx, FLASH_ERASED);
  wire        pw_match   = (RX.data == exp_pw); // compare to stored copy
  wire [7:0]  sum_total  = sum + RX.data;       // sum incl. checksum
  wire        sum_good   = (sum_total == `FBR_ZERO8);
  wire        tx_done    = TX_VALID & TX_READY; // ack accepted
  wire        last_pw    = (pw_idx == `FBR_PW_LAST);
  wire        pass_now   = ~comm_err & ~pw_err; // set when ack is ok
  wire        room_left  = (wire_le(wr_addr));  // inside ram window
  wire        load_write = (state == FBR_ST_LOAD) & rx_ok & room_left;
  wire        load_last  = load_write & (remain == `FBR_ONE16);

  ////////////////////////////////////////////////////////////////////
  // next state selection
  always_comb begin
    next_state = state;
    case (state)
      // first edge after release: decide boot path from the strap
      FBR_ST_STRAP: begin
        if (BOOT_PIN) begin
          next_state = FBR_ST_CMD;
        end else begin
          next_state = FBR_ST_RUN;
        end
      end
      // normal application; its mode check may raise user boot
      FBR_ST_RUN: begin
        if (USER_BOOT_REQ) begin
          next_state = FBR_ST_USER;
        end
      end
      // wait for the load command from the host
      FBR_ST_CMD: begin
        if (rx_ok && RX.data == `FBR_CMD_LOAD) begin
          next_state = FBR_ST_PW;
        end
      end
      // collect password bytes
      FBR_ST_PW: begin
        if (RX.valid && last_pw) begin
          next_state = FBR_ST_SUM;
        end
      end
      // checksum byte closes the password frame
      FBR_ST_SUM: begin
        if (RX.valid) begin
          next_state = FBR_ST_ACK;
        end
      end
      // hold ack until sent; a failure falls back to command wait
      FBR_ST_ACK: begin
        if (tx_done) begin
          next_state = load_ok ? FBR_ST_LEN0 : FBR_ST_CMD;
        end
      end
      // routine length, low byte first
      FBR_ST_LEN0: begin
        if (rx_ok) begin
          next_state = FBR_ST_LEN1;
        end
      end
      FBR_ST_LEN1: begin
        if (rx_ok) begin
          next_state = FBR_ST_LOAD;
        end
      end
      // copy routine bytes; leaving the ram window aborts the load
      FBR_ST_LOAD: begin
        if (remain == `FBR_ZERO16) begin
          next_state = FBR_ST_EXEC;
        end else if (load_last) begin
          next_state = FBR_ST_EXEC;
        end else if (rx_ok && !room_left) begin
          next_state = FBR_ST_CMD;
        end
      end
      // routine owns the cpu until the next reset
      FBR_ST_EXEC: next_state = FBR_ST_EXEC;
      FBR_ST_USER: next_state = FBR_ST_USER;
      default:     next_state = FBR_ST_STRAP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register; reset always lands in strap decode
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= FBR_ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // password frame bookkeeping
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pw_idx   <= `FBR_ZERO4;
      sum      <= `FBR_ZERO8;
      comm_err <= 1'b0;
      pw_err   <= 1'b0;
      load_ok  <= 1'b0;
    end else if (state == FBR_ST_CMD) begin
      // clear for a fresh frame
      pw_idx   <= `FBR_ZERO4;
      sum      <= `FBR_ZERO8;
      comm_err <= 1'b0;
      pw_err   <= 1'b0;
      load_ok  <= 1'b0;
    end else if (state == FBR_ST_PW && RX.valid) begin
      pw_idx   <= pw_idx + `FBR_ONE4;
      sum      <= sum_total;
      comm_err <= comm_err | RX.err;
      pw_err   <= pw_err | ~pw_match;
    end else if (state == FBR_ST_SUM && RX.valid) begin
      // bad checksum is reported like a bad password
      comm_err <= comm_err | RX.err;
      pw_err   <= pw_err | ~sum_good;
      load_ok  <= pass_now & ~RX.err & sum_good;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // acknowledge transmitter; comm error outranks check failures
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= `FBR_ZERO8;
    end else if (state == FBR_ST_SUM && RX.valid) begin
      TX_VALID <= 1'b1;
      if (comm_err || RX.err) begin
        TX_DATA <= `FBR_ACK_COMM;
      end else if (pw_err || !sum_good) begin
        TX_DATA <= `FBR_ACK_BAD;
      end else begin
        TX_DATA <= `FBR_ACK_OK;
      end
    end else if (tx_done) begin
      TX_VALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // routine copy into ram
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      remain  <= `FBR_ZERO16;
      wr_addr <= `FBR_RAM_START;
      RAM_WR  <= '0;
    end else begin
      RAM_WR.we <= 1'b0;
      if (state == FBR_ST_LEN0 && rx_ok) begin
        remain[7:0] <= RX.data;
        wr_addr     <= `FBR_RAM_START;
      end else if (state == FBR_ST_LEN1 && rx_ok) begin
        remain[15:8] <= RX.data;
      end else if (load_write && load_ok) begin
        // only a passed frame ever reaches ram
        RAM_WR.we   <= 1'b1;
        RAM_WR.addr <= wr_addr;
        RAM_WR.data <= RX.data;
        wr_addr     <= wr_addr + 32'h0000_0001;
        remain      <= remain - `FBR_ONE16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // hand-off pulse to the ram routine
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      EXEC_GO   <= 1'b0;
      EXEC_ADDR <= `FBR_ZERO32;
    end else begin
      EXEC_GO <= (state == FBR_ST_LOAD) && (next_state == FBR_ST_EXEC);
      if ((state == FBR_ST_LOAD) && (next_state == FBR_ST_EXEC)) begin
        EXEC_ADDR <= `FBR_RAM_START;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flash mode and read gating; a busy array returns zero, not data
  wire fbr_flash_mode_t mode_sel =
    (next_state == FBR_ST_USER) ? FBR_FM_USER :
    ((next_state == FBR_ST_RUN) || (next_state == FBR_ST_STRAP)) ? FBR_FM_NORMAL : FBR_FM_SERIAL;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FLASH_MODE  <= FBR_FM_NORMAL;
      FLASH_RDATA <= `FBR_ZERO32;
    end else begin
      FLASH_MODE  <= mode_sel;
      FLASH_RDATA <= FLASH_BUSY ? `FBR_ZERO32 : FLASH_RDATA_IN;
    end
  end
endmodule

//--- src/fbr_map.svh
// constants for the flash boot reprogramming controller
// assumes a single 50 MHz clock domain and byte-wide serial transfers
`ifndef FBR_MAP_SVH
`define FBR_MAP_SVH
// acknowledge codes returned for the checksum byte
`define FBR_ACK_OK      8'h40
`define FBR_ACK_BAD     8'h41
`define FBR_ACK_COMM    8'h48
// operation command that opens a routine load
`define FBR_CMD_LOAD    8'h30
// value an erased flash byte reads as, used as password
`define FBR_ERASED_BYTE 8'hFF
// number of password bytes sent by the host
`define FBR_PW_LEN      4'h8
`define FBR_PW_LAST     4'h7
`define FBR_PW_BITS     64
// first ram address the routine may occupy
`define FBR_RAM_START   32'h2000_0400
// last valid ram address
`define FBR_RAM_END     32'h2000_0FFF
`define FBR_ZERO8       8'h00
`define FBR_ZERO16      16'h0000
`define FBR_ONE16       16'h0001
`define FBR_ZERO32      32'h0000_0000
`define FBR_ZERO4       4'h0
`define FBR_ONE4        4'h1
`endif

//--- src/fbr_pkg.sv
// types shared by the flash boot reprogramming controller
// assumes fbr_map.svh supplies all numeric constants
package fbr_pkg;
  // receive byte from the serial channel
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } fbr_rx_t;
  // one byte written into on-chip ram
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [7:0]  data;
  } fbr_ram_wr_t;
  // mode the flash array is put in
  typedef enum logic [1:0] {
    FBR_FM_NORMAL = 2'b00,
    FBR_FM_SERIAL = 2'b01,
    FBR_FM_USER   = 2'b10
  } fbr_flash_mode_t;
  // controller states
  typedef enum logic [3:0] {
    FBR_ST_STRAP = 4'b0000,
    FBR_ST_RUN   = 4'b0001,
    FBR_ST_CMD   = 4'b0010,
    FBR_ST_PW    = 4'b0011,
    FBR_ST_SUM   = 4'b0100,
    FBR_ST_ACK   = 4'b0101,
    FBR_ST_LEN0  = 4'b0110,
    FBR_ST_LEN1  = 4'b0111,
    FBR_ST_LOAD  = 4'b1000,
    FBR_ST_EXEC  = 4'b1001,
    FBR_ST_USER  = 4'b1010
  } fbr_state_t;
endpackage

//--- test/fbr_boot_assertions.sv
// checker for the flash boot controller, watching its top ports only
// assumes one clock domain with an async active-low reset
`include "fbr_map.svh"
module fbr_boot_checker (
  input wire logic                     CLK,
  input wire logic                     RST_B,
  input wire logic                     BOOT_PIN,
  input wire logic                     USER_BOOT_REQ,
  input wire logic                     TX_VALID,
  input wire logic [7:0]               TX_DATA,
  input wire logic                     TX_READY,
  input wire fbr_pkg::fbr_ram_wr_t     RAM_WR,
  input wire logic                     EXEC_GO,
  input wire logic [31:0]              EXEC_ADDR,
  input wire fbr_pkg::fbr_flash_mode_t FLASH_MODE,
  input wire logic                     FLASH_BUSY,
  input wire logic [31:0]              FLASH_RDATA_IN,
  input wire logic [31:0]              FLASH_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbr_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ack offered but not yet taken, then still offered with the same code
  sequence s_ack_wait; TX_VALID && !TX_READY; endsequence
  sequence s_ack_held; TX_VALID && $stable(TX_DATA); endsequence
  a_ack_stands: assert property (s_ack_wait |=> s_ack_held)
    else $error("ack withdrawn before the host took it");
  a_ack_code: assert property (TX_VALID |-> TX_DATA inside {`FBR_ACK_OK, `FBR_ACK_BAD, `FBR_ACK_COMM})
    else $error("ack byte outside the three codes");
  a_read_gated: assert property (FLASH_BUSY |=> FLASH_RDATA == `FBR_ZERO32)
    else $error("array data leaked while busy");
  a_read_pass: assert property (!FLASH_BUSY |=> FLASH_RDATA == $past(FLASH_RDATA_IN))
    else $error("array data not passed when idle");
  a_exec_addr: assert property (EXEC_GO |-> EXEC_ADDR == `FBR_RAM_START)
    else $error("jump target is not the ram start");
  a_exec_pulse: assert property (EXEC_GO |=> !EXEC_GO)
    else $error("jump pulse longer than one cycle");
  a_wr_range: assert property (RAM_WR.we |-> RAM_WR.addr inside {[`FBR_RAM_START:`FBR_RAM_END]})
    else $error("ram write outside routine area");
  a_mode_reset: assert property ($rose(RST_B) |-> FLASH_MODE == FBR_FM_NORMAL)
    else $error("flash not normal coming out of reset");
  a_user_entry: assert property (USER_BOOT_REQ && !BOOT_PIN && FLASH_MODE == FBR_FM_NORMAL
    |-> ##[1:4] FLASH_MODE == FBR_FM_USER)
    else $error("user boot not entered");
  a_user_stays: assert property (FLASH_MODE == FBR_FM_USER |=> FLASH_MODE == FBR_FM_USER)
    else $error("user boot left without reset");
endmodule
bind fbr_boot_ctrl fbr_boot_checker chk (
  .CLK(CLK), .RST_B(RST_B), .BOOT_PIN(BOOT_PIN), .USER_BOOT_REQ(USER_BOOT_REQ),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .RAM_WR(RAM_WR),
  .EXEC_GO(EXEC_GO), .EXEC_ADDR(EXEC_ADDR), .FLASH_MODE(FLASH_MODE),
  .FLASH_BUSY(FLASH_BUSY), .FLASH_RDATA_IN(FLASH_RDATA_IN), .FLASH_RDATA(FLASH_RDATA)
);

//--- test/fbr_host_model.sv
// external host on serial channel zero: sends bytes, takes acks
// assumes the bench calls send and idle from one process
module fbr_host_model (
  input  wire logic        clk,
  output fbr_pkg::fbr_rx_t rx,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbr_pkg::*;
  int         lag = 0;     // cycles the host lets an ack wait
  int         n_wait = 0;  // cycles the current ack has waited
  int         n_ack = 0;   // acks taken so far
  logic [7:0] ack = 8'h00; // last ack byte taken
  initial begin
    rx = '0;
    tx_ready = 1'h0;
  end
  // slow host: ready only after lag cycles, so held acks are exercised
  always @(negedge clk) begin
    n_wait <= tx_valid ? n_wait + 1 : 0;
    tx_ready <= tx_valid && n_wait >= lag;
  end
  // the ack byte is taken at the edge that sees ready high
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      ack <= tx_data;
      n_ack <= n_ack + 1;
    end
  end
  // one byte, one cycle valid
  task send(input logic [7:0] b, input logic e);
    @(negedge clk);
    rx = '{valid: 1'h1, err: e, data: b};
  endtask
  // released line: no stale copy of the last byte
  task idle;
    @(negedge clk);
    rx = '{valid: 1'h0, err: 1'h0, data: ~rx.data};
  endtask
endmodule

//--- test/tb_flash_boot_reprogramming.sv
// self-checking bench for the flash boot reprogramming controller
// assumes the host model on the serial side and the bound checker
`include "fbr_map.svh"
module tb_flash_boot_reprogramming;
  timeunit 1ns;
  timeprecision 1ps;
  import fbr_pkg::*;
  typedef struct {
    logic er, ff, e;
    logic [7:0] flip, sx, ack;
    logic [15:0] len;
  } fbr_row_t;
  logic            clk = 1'h0;
  logic            rst_b = 1'h0;
  logic            boot_pin = 1'h1;
  logic            user_req = 1'h0;
  logic            erased = 1'h0;
  logic [63:0]     pw = 64'h0123_4567_89AB_CDEF;
  logic            busy = 1'h0;
  logic [31:0]     rd_in = 32'h0000_0000;
  fbr_rx_t         rx;
  logic            tx_valid, tx_ready, exec_go;
  logic [7:0]      tx_data, wr_d;
  fbr_ram_wr_t     ram_wr;
  logic [31:0]     exec_addr, rdata, wr_a;
  fbr_flash_mode_t mode;
  int              n_fail = 0;
  int              checks_done = 0;
  int              n_wr = 0;
  int              n_exec = 0;
  // er ff e flip sx ack len
  fbr_row_t rows [6] = '{
    '{1'h0, 1'h0, 1'h0, 8'h01, 8'h00, `FBR_ACK_BAD, 16'h0002},  // wrong password byte
    '{1'h0, 1'h0, 1'h0, 8'h00, 8'h01, `FBR_ACK_BAD, 16'h0002},  // bad checksum
    '{1'h0, 1'h0, 1'h1, 8'h00, 8'h01, `FBR_ACK_COMM, 16'h0002}, // receive error wins
    '{1'h0, 1'h0, 1'h0, 8'h00, 8'h00, `FBR_ACK_OK, 16'h0003},   // good, three bytes
    '{1'h1, 1'h0, 1'h0, 8'h00, 8'h00, `FBR_ACK_BAD, 16'h0002},  // erased, stored bytes sent
    '{1'h1, 1'h1, 1'h0, 8'h00, 8'h00, `FBR_ACK_OK, 16'h0000}};  // erased, empty routine
  fbr_boot_ctrl uut (.CLK(clk), .RST_B(rst_b), .BOOT_PIN(boot_pin), .USER_BOOT_REQ(user_req),
    .FLASH_ERASED(erased), .STORED_PW(pw), .RX(rx), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .RAM_WR(ram_wr), .EXEC_GO(exec_go), .EXEC_ADDR(exec_addr),
    .FLASH_MODE(mode), .FLASH_BUSY(busy), .FLASH_RDATA_IN(rd_in), .FLASH_RDATA(rdata));
  fbr_host_model host (.clk(clk), .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  // ram writes and jumps as the cpu side would see them
  always @(posedge clk) begin
    if (ram_wr.we) begin
      n_wr <= n_wr + 1;
      wr_a <= ram_wr.addr;
      wr_d <= ram_wr.data;
    end
    if (exec_go) n_exec <= n_exec + 1;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // strap is held through the whole reset so it is stable at release
  task do_reset(input logic bp);
    @(negedge clk);
    rst_b = 1'h0;
    boot_pin = bp;
    repeat (8) @(negedge clk);
    rst_b = 1'h1;
    repeat (3) @(negedge clk);
  endtask
  // load command, password with optional faults, checksum
  task session(input fbr_row_t w);
    logic [7:0] s;
    logic [7:0] b;
    s = 8'h00;
    host.send(`FBR_CMD_LOAD, 1'h0);
    for (int i = 0; i < 8; i++) begin
      b = w.ff ? `FBR_ERASED_BYTE : pw[i*8 +: 8];
      b = (i == 3) ? b ^ w.flip : b;
      s = s + b;
      host.send(b, w.e && i == 5);
    end
    host.send((8'h00 - s) ^ w.sx, 1'h0);
    host.idle;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial begin
    int n0;
    do_reset(1'h1);
    foreach (rows[r]) begin
      erased = rows[r].er;
      host.lag = r;
      n_wr = 0;
      n_exec = 0;
      n0 = host.n_ack;
      session(rows[r]);
      for (int i = 0; i < 40 && host.n_ack == n0; i++) @(negedge clk);
      chk("ack", rows[r].ack, host.ack);
      chk("mode", FBR_FM_SERIAL, mode);
      // header and body go out after every ack, so a refused frame is tested
      // a corrupted byte first: it must be ignored, not taken as length
      host.send(8'h5A, 1'h1);
      // short routine keeps well inside the ram area
      host.send(rows[r].len[7:0], 1'h0);
      host.send(rows[r].len[15:8], 1'h0);
      for (int k = 0; k < rows[r].len; k++) host.send(8'hA0 + k[7:0], 1'h0);
      host.idle;
      repeat (3) @(negedge clk);
      if (rows[r].ack === `FBR_ACK_OK) begin
        chk("writes", rows[r].len, n_wr);
        if (rows[r].len > 0) chk("addr", `FBR_RAM_START + rows[r].len - 1, wr_a);
        if (rows[r].len > 0) chk("data", 8'hA0 + rows[r].len[7:0] - 8'h01, wr_d);
        chk("jumps", 1, n_exec);
        chk("jump_addr", `FBR_RAM_START, exec_addr);
        // routine erases and reprograms; array data must stay hidden meanwhile
        rd_in = 32'h5A5A_0001;
        busy = 1'h1;
        repeat (2) @(negedge clk);
        chk("rdata", 0, rdata);
        busy = 1'h0;
        do_reset(1'h1);
      end else chk("refused", 0, n_wr + n_exec);
    end
    // normal start ignores the serial loader
    do_reset(1'h0);
    chk("mode", FBR_FM_NORMAL, mode);
    session(rows[3]);
    repeat (4) @(negedge clk);
    chk("ack_offered", 0, tx_valid);
    rd_in = 32'h1234_5678;
    busy = 1'h1;
    repeat (2) @(negedge clk);
    chk("rdata", 0, rdata);
    busy = 1'h0;
    repeat (2) @(negedge clk);
    chk("rdata", 32'h1234_5678, rdata);
    // no interrupt source is modelled while user boot runs
    user_req = 1'h1;
    repeat (5) @(negedge clk);
    chk("mode", FBR_FM_USER, mode);
    user_req = 1'h0;
    rst_b = 1'h0;
    @(negedge clk);
    chk("mode", FBR_FM_NORMAL, mode);
    rst_b = 1'h1;
    repeat (3) @(negedge clk);
    chk("mode", FBR_FM_NORMAL, mode);
    test_done;
  end
endmodule
